//--- hw/iarc_pkg.sv
package iarc_pkg;
  localparam int NUM_INST  = 4;
  localparam int KIND_W    = 6;
  localparam int CNT_W     = 16;
  localparam int MSG_DEPTH = 16;

  localparam logic [7:0] CHAR_LF   = 8'h0A;
  localparam logic [7:0] OP_DEFER  = 8'h41;
  localparam logic [7:0] OP_IMM    = 8'h49;
  localparam logic [7:0] OP_INIT   = 8'h47;
  localparam logic [7:0] OP_CONF   = 8'h43;
  localparam logic [7:0] OP_QUERY  = 8'h51;
  localparam logic [7:0] OP_MEAS   = 8'h4D;

  localparam int ARG_INST_LSB = 0;
  localparam int ARG_KIND_LSB = 2;

  localparam logic ABORT_BIT_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ABORT = 3'b010,
    ST_EXEC  = 3'b100
  } iarc_state_t;
endpackage

//--- hw/iarc_msg_if.sv
`timescale 1ns/10ps
interface iarc_msg_if;
  logic       valid;
  logic       ready;
  logic [7:0] opcode;
  logic [7:0] arg;

  modport src (output valid, output opcode, output arg, input ready);
  modport dst (input valid, input opcode, input arg, output ready);
endinterface

//--- hw/iarc_term_buf.sv
`timescale 1ns/10ps
module iarc_term_buf
  import iarc_pkg::*;
#(
  parameter int DEPTH = MSG_DEPTH
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  input  wire logic       i_rx_end,
  output logic            o_rx_ready,
  iarc_msg_if.src         msg
);
  localparam int PW = $clog2(DEPTH) + 1;

  logic [7:0]    mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] next_wr_ptr;
  logic          pending;
  logic          next_pending;
  logic          rx_ready;
  logic          next_rx_ready;
  logic          wr_en;
  logic          rx_take;
  logic          is_term;

  assign rx_take = i_rx_valid && rx_ready;
  assign is_term = (i_rx_data == CHAR_LF) || i_rx_end;

  always_comb begin
    next_wr_ptr  = wr_ptr;
    next_pending = pending;
    wr_en        = 1'b0;
    if (pending && msg.ready) begin
      next_pending = 1'b0;
      next_wr_ptr  = '0;
    end else if (rx_take) begin
      if (i_rx_data != CHAR_LF && wr_ptr < PW'(DEPTH)) begin
        wr_en       = 1'b1;
        next_wr_ptr = wr_ptr + PW'(1);
      end
      // Terminator closes a non-empty message
      if (is_term && (i_rx_data != CHAR_LF || wr_ptr != '0)) begin
        next_pending = 1'b1;
      end
    end
    next_rx_ready = ~next_pending;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr   <= '0;
      pending  <= 1'b0;
      rx_ready <= 1'b1;
    end else begin
      wr_ptr   <= next_wr_ptr;
      pending  <= next_pending;
      rx_ready <= next_rx_ready;
    end
  end

  always_ff @(posedge i_clock) begin
    if (wr_en) begin
      mem[wr_ptr[PW-2:0]] <= i_rx_data;
    end
  end

  assign o_rx_ready = rx_ready;
  assign msg.valid  = pending;
  assign msg.opcode = mem[0];
  assign msg.arg    = mem[1];

  term_close_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    rx_take && i_rx_end && (i_rx_data != CHAR_LF || wr_ptr != '0)
    |=> msg.valid && !o_rx_ready
  ) else $error("terminator did not close message");
endmodule

//--- hw/iarc_run_ctrl.sv
`timescale 1ns/10ps
module iarc_run_ctrl
  import iarc_pkg::*;
#(
  parameter int NUM   = NUM_INST,
  parameter int KW    = KIND_W,
  parameter int CW    = CNT_W,
  parameter int DEPTH = MSG_DEPTH
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_rx_valid,
  input  wire logic [7:0]        i_rx_data,
  input  wire logic              i_rx_end,
  input  wire logic              i_async_mode,
  input  wire logic [NUM-1:0]    i_seg_done,
  input  wire logic [NUM-1:0]    i_sample_tick,
  input  wire logic              i_query_done,
  output logic                   o_rx_ready,
  output logic [NUM-1:0]         o_run,
  output logic [NUM-1:0]         o_defer_pend,
  output logic [NUM*KW-1:0]      o_kind,
  output logic [NUM*CW-1:0]      o_count,
  output logic                   o_abort_bit,
  output logic                   o_query_busy
);
  iarc_msg_if msg ();

  iarc_term_buf #(
    .DEPTH (DEPTH)
  ) u_term_buf (
    .i_clock    (i_clock),
    .i_rst_n    (i_rst_n),
    .i_rx_valid (i_rx_valid),
    .i_rx_data  (i_rx_data),
    .i_rx_end   (i_rx_end),
    .o_rx_ready (o_rx_ready),
    .msg        (msg)
  );

  // Commands that reconfigure or start a measurement
  function automatic logic is_cfg(input logic [7:0] op);
    is_cfg = (op == OP_CONF) || (op == OP_INIT) || (op == OP_MEAS);
  endfunction

  function automatic logic [NUM-1:0] inst_sel(input logic [7:0] arg);
    logic [NUM-1:0] sel;
    sel = '0;
    for (int k = 0; k < NUM; k++) begin
      if (k == int'(arg[ARG_KIND_LSB-1:ARG_INST_LSB])) begin
        sel[k] = 1'b1;
      end
    end
    inst_sel = sel;
  endfunction

  iarc_state_t   state;
  iarc_state_t   next_state;
  logic [NUM-1:0]    run;
  logic [NUM-1:0]    next_run;
  logic [NUM-1:0]    pend_def;
  logic [NUM-1:0]    next_pend_def;
  logic [NUM*KW-1:0] kind;
  logic [NUM*KW-1:0] next_kind;
  logic [NUM*CW-1:0] count;
  logic [NUM*CW-1:0] next_count;
  logic              abort_bit;
  logic              next_abort_bit;
  logic              query_busy;
  logic              next_query_busy;
  logic [7:0]        hold_op;
  logic [7:0]        next_hold_op;
  logic [7:0]        hold_arg;
  logic [7:0]        next_hold_arg;
  logic              take;
  logic              clr_all;
  logic              defer_req;
  logic [NUM-1:0]    sel;
  logic [NUM-1:0]    done_now;
  logic              pend_k;

  assign sel      = inst_sel(hold_arg);
  assign done_now = pend_def & i_seg_done;

  always_comb begin
    next_state      = state;
    next_run        = run;
    next_pend_def   = pend_def;
    next_kind       = kind;
    next_count      = count;
    next_abort_bit  = abort_bit;
    next_query_busy = query_busy;
    next_hold_op    = hold_op;
    next_hold_arg   = hold_arg;
    take            = 1'b0;
    clr_all         = 1'b0;
    defer_req       = 1'b0;
    pend_k          = 1'b0;

    if (i_query_done) begin
      next_query_busy = 1'b0;
    end

    case (state)
      ST_IDLE: begin
        if (msg.valid) begin
          if (msg.opcode == OP_DEFER) begin
            take      = 1'b1;
            defer_req = 1'b1;
          end else if (query_busy && !i_async_mode) begin
            take = 1'b0;
          end else if (msg.opcode == OP_IMM) begin
            take    = 1'b1;
            clr_all = 1'b1;
          end else begin
            take          = 1'b1;
            next_hold_op  = msg.opcode;
            next_hold_arg = msg.arg;
            if (is_cfg(msg.opcode) && (|run)) begin
              clr_all    = 1'b1;
              next_state = ST_ABORT;
            end else begin
              next_state = ST_EXEC;
            end
          end
        end
      end
      ST_ABORT: begin
        next_abort_bit = ~abort_bit;
        next_state     = ST_EXEC;
      end
      ST_EXEC: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    for (int k = 0; k < NUM; k++) begin
      // Count readings only while running
      if (run[k] && i_sample_tick[k]) begin
        next_count[k*CW +: CW] = count[k*CW +: CW] + CW'(1);
      end
      // Deferred stop at segment end
      pend_k = pend_def[k] | (defer_req & run[k]);
      if (pend_k && i_seg_done[k]) begin
        next_run[k]      = 1'b0;
        next_pend_def[k] = 1'b0;
      end else begin
        next_pend_def[k] = pend_k & run[k];
      end
    end

    if (clr_all) begin
      next_run      = '0;
      next_pend_def = '0;
    end

    if (state == ST_EXEC) begin
      for (int k = 0; k < NUM; k++) begin
        if (sel[k]) begin
          // Only execute writes kind, aborts never
          if (hold_op == OP_CONF || hold_op == OP_MEAS) begin
            next_kind[k*KW +: KW] = hold_arg[ARG_KIND_LSB +: KW];
          end
          // Initiate restart keeps stored kind; measure restarts with the kind just written above
          if (hold_op == OP_INIT || hold_op == OP_MEAS) begin
            next_run[k]            = 1'b1;
            next_pend_def[k]       = 1'b0;
            next_count[k*CW +: CW] = '0;
          end
        end
      end
      if (hold_op == OP_QUERY || hold_op == OP_MEAS) begin
        next_query_busy = 1'b1;
      end
    end
  end

  assign msg.ready = take;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state      <= ST_IDLE;
      run        <= '0;
      pend_def   <= '0;
      kind       <= '0;
      count      <= '0;
      abort_bit  <= ABORT_BIT_RST;
      query_busy <= 1'b0;
      hold_op    <= '0;
      hold_arg   <= '0;
    end else begin
      state      <= next_state;
      run        <= next_run;
      pend_def   <= next_pend_def;
      kind       <= next_kind;
      count      <= next_count;
      abort_bit  <= next_abort_bit;
      query_busy <= next_query_busy;
      hold_op    <= next_hold_op;
      hold_arg   <= next_hold_arg;
    end
  end

  assign o_run        = run;
  assign o_defer_pend = pend_def;
  assign o_kind       = kind;
  assign o_count      = count;
  assign o_abort_bit  = abort_bit;
  assign o_query_busy = query_busy;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  def_wait_a: assert property (
    !clr_all && state != ST_EXEC
    |=> (($past(run) & ~run & ~$past(i_seg_done)) == '0)
  ) else $error("deferred abort stopped before segment end");

  imm_abort_a: assert property (
    take && msg.opcode == OP_IMM |=> run == '0 && pend_def == '0
  ) else $error("immediate abort left an instrument running");

  cfg_keep_a: assert property (
    clr_all |=> $stable(kind)
  ) else $error("abort changed configuration");

  restart_kind_a: assert property (
    state == ST_EXEC && hold_op == OP_INIT
    |=> $stable(kind) && ((run & $past(sel)) != '0)
  ) else $error("initiate did not restart stored kind");

  def_accept_a: assert property (
    msg.valid && state == ST_IDLE && msg.opcode == OP_DEFER
    |-> msg.ready
  ) else $error("deferred abort not accepted");

  implicit_abort_a: assert property (
    take && is_cfg(msg.opcode) && (|run)
    |=> state == ST_ABORT && run == '0
  ) else $error("no implicit abort before reconfiguration");

  toggle_exec_a: assert property (
    state == ST_ABORT
    |=> abort_bit != $past(abort_bit) && state == ST_EXEC ##1 state == ST_IDLE
  ) else $error("abort bit toggle or execute order wrong");

  async_take_a: assert property (
    msg.valid && state == ST_IDLE && query_busy && i_async_mode
    |-> msg.ready
  ) else $error("async command refused during query");

  sync_queue_a: assert property (
    msg.valid && query_busy && !i_async_mode && msg.opcode != OP_DEFER
    |-> !msg.ready
  ) else $error("sync command taken during query");

  count_frozen_a: assert property (
    run == '0 && state != ST_EXEC |=> $stable(count)
  ) else $error("readings counted while idle");

  flag_clear_a: assert property (
    done_now != '0 && state != ST_EXEC
    |=> (run & $past(done_now)) == '0
  ) else $error("run flag not cleared at segment end");

  abort_hold_a: assert property (
    state != ST_ABORT
    |=> abort_bit == $past(abort_bit)
  ) else $error("abort bit moved outside implicit abort");

  abort_order_a: assert property (
    state != ST_IDLE
    |-> !msg.ready
  ) else $error("command taken before abort finished");

  pend_run_a: assert property (
    pend_def != '0
    |-> (pend_def & ~run) == '0
  ) else $error("deferred abort pending on idle instrument");

  defer_set_a: assert property (
    take && msg.opcode == OP_DEFER
    |=> (($past(run) & ~$past(i_seg_done) & ~pend_def) == '0)
  ) else $error("running instrument missed deferred abort");

  query_pass_a: assert property (
    take && msg.opcode == OP_QUERY
    |=> state == ST_EXEC
  ) else $error("plain query forced an abort");

  busy_set_a: assert property (
    state == ST_EXEC && (hold_op == OP_QUERY || hold_op == OP_MEAS)
    |=> query_busy
  ) else $error("query in progress not flagged");

  busy_clear_a: assert property (
    i_query_done && state != ST_EXEC
    |=> !query_busy
  ) else $error("query completion not seen");
endmodule

//--- test/iarc_host_model.sv
`timescale 1ns/10ps
module iarc_host_model (
  input  wire logic       i_clock,
  input  wire logic       i_rx_ready,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_end,
  output logic            o_timeout
);
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_rx_end   = 1'b0;
    o_timeout  = 1'b0;
  end

  // One byte, held until ready is seen at a falling edge, then through the next rising edge
  task automatic put(input logic [7:0] b, input logic e);
    int n;
    n = 0;
    @(negedge i_clock);
    o_rx_valid = 1'b1;
    o_rx_data  = b;
    o_rx_end   = e;
    while (!i_rx_ready && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    if (n == 200)
      o_timeout = 1'b1;
    @(posedge i_clock);
  endtask

  // Opcode, argument, then line feed or end indication
  task automatic send(input logic [7:0] op, input logic [7:0] arg,
                      input logic use_end);
    put(op, 1'b0);
    if (use_end) begin
      put(arg, 1'b1);
    end else begin
      put(arg, 1'b0);
      put(8'h0A, 1'b0);
    end
    @(negedge i_clock);
    o_rx_valid = 1'b0;
    o_rx_data  = ~o_rx_data;
    o_rx_end   = 1'b0;
  endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import iarc_pkg::*;
  logic                    i_clock;
  logic                    i_rst_n;
  logic                    rx_valid;
  logic [7:0]              rx_data;
  logic                    rx_end;
  logic                    async_mode;
  logic [NUM_INST-1:0]     seg_done;
  logic [NUM_INST-1:0]     sample_tick;
  logic                    query_done;
  logic                    rx_ready;
  logic [NUM_INST-1:0]     run;
  logic [NUM_INST-1:0]     defer_pend;
  logic [NUM_INST*KIND_W-1:0] kind;
  logic [NUM_INST*CNT_W-1:0]  count;
  logic                    abort_bit;
  logic                    query_busy;
  logic                    tmo;
  logic                    exp_ab;
  int                      fails;
  int                      cmp_count;
  int                      k;
  int                      n;
  logic [5:0]              kd;

  iarc_run_ctrl i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_end(rx_end),
    .i_async_mode(async_mode), .i_seg_done(seg_done),
    .i_sample_tick(sample_tick), .i_query_done(query_done),
    .o_rx_ready(rx_ready), .o_run(run), .o_defer_pend(defer_pend),
    .o_kind(kind), .o_count(count), .o_abort_bit(abort_bit),
    .o_query_busy(query_busy));
  iarc_host_model i_host (.i_clock(i_clock), .i_rx_ready(rx_ready),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_end(rx_end),
    .o_timeout(tmo));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  function automatic logic [7:0] arg_of(input int i, input logic [5:0] t);
    return {t, i[1:0]};
  endfunction
  function automatic logic [31:0] kind_of(input int i);
    return 32'(kind[i*KIND_W +: KIND_W]);
  endfunction
  function automatic logic [31:0] count_of(input int i);
    return 32'(count[i*CNT_W +: CNT_W]);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_idle;
    int w;
    w = 0;
    while ((!rx_ready || tmo) && w < 200) begin
      @(negedge i_clock);
      w++;
    end
    if (w == 200 || tmo === 1'b1) begin
      fails++;
      give_verdict;
    end
    repeat (4) @(negedge i_clock);
  endtask

  task automatic cmd(input logic [7:0] op, input int i, input logic [5:0] t,
                     input logic e);
    i_host.send(op, arg_of(i, t), e);
    wait_idle;
  endtask

  task automatic ticks(input int i, input int m);
    repeat (m) begin
      sample_tick[i] = 1'b1;
      @(negedge i_clock);
      sample_tick[i] = 1'b0;
      @(negedge i_clock);
    end
  endtask

  initial begin
    fails = 0;
    cmp_count = 0;
    i_rst_n = 1'b0;
    async_mode = 1'b0;
    seg_done = '0;
    sample_tick = '0;
    query_done = 1'b0;
    exp_ab = ABORT_BIT_RST;
    void'($urandom(8315));
    repeat (3) @(negedge i_clock);
    i_rst_n = 1'b1;
    chk("ready", 32'(rx_ready), 32'h0000_0001);
    chk("run", 32'(run), 32'h0000_0000);
    chk("abort", 32'(abort_bit), 32'(exp_ab));
    for (int r = 0; r < NUM_INST; r++) begin
      k = r;
      kd = 6'($urandom_range(63, 1));
      n = $urandom_range(9, 1);
      cmd(OP_CONF, k, kd, r[0]);
      chk("kind", kind_of(k), 32'(kd));
      chk("abort", 32'(abort_bit), 32'(exp_ab));
      cmd(OP_INIT, k, kd, 1'b0);
      chk("run", 32'(run[k]), 32'h0000_0001);
      ticks(k, n);
      chk("count", count_of(k), 32'(n));
      kd = kd ^ 6'h01;
      exp_ab = ~exp_ab;
      cmd(OP_CONF, k, kd, 1'b0);
      chk("abort", 32'(abort_bit), 32'(exp_ab));
      chk("run", 32'(run[k]), 32'h0000_0000);
      chk("kind", kind_of(k), 32'(kd));
      ticks(k, 2);
      chk("count", count_of(k), 32'(n));
      cmd(OP_INIT, k, kd, 1'b0);
      chk("kind", kind_of(k), 32'(kd));
      chk("count", count_of(k), 32'h0000_0000);
      cmd(OP_IMM, k, kd, 1'b0);
      chk("run", 32'(run), 32'h0000_0000);
      chk("abort", 32'(abort_bit), 32'(exp_ab));
      chk("kind", kind_of(k), 32'(kd));
      ticks(k, 3);
      chk("count", count_of(k), 32'h0000_0000);
    end
    cmd(OP_INIT, 1, 6'h05, 1'b0);
    exp_ab = ~exp_ab;
    cmd(OP_MEAS, 2, 6'h07, 1'b0);
    chk("abort", 32'(abort_bit), 32'(exp_ab));
    chk("busy", 32'(query_busy), 32'h0000_0001);
    chk("run", 32'(run), 32'h0000_0004);
    cmd(OP_DEFER, 2, 6'h00, 1'b0);
    chk("pend", 32'(defer_pend[2]), 32'h0000_0001);
    chk("run", 32'(run[2]), 32'h0000_0001);
    seg_done[2] = 1'b1;
    @(negedge i_clock);
    seg_done[2] = 1'b0;
    repeat (2) @(negedge i_clock);
    chk("run", 32'(run[2]), 32'h0000_0000);
    chk("pend", 32'(defer_pend[2]), 32'h0000_0000);
    chk("kind", kind_of(2), 32'h0000_0007);
    i_host.send(OP_INIT, arg_of(3, 6'h07), 1'b0);
    repeat (6) @(negedge i_clock);
    chk("run", 32'(run[3]), 32'h0000_0000);
    chk("ready", 32'(rx_ready), 32'h0000_0000);
    query_done = 1'b1;
    @(negedge i_clock);
    query_done = 1'b0;
    wait_idle;
    chk("run", 32'(run[3]), 32'h0000_0001);
    chk("busy", 32'(query_busy), 32'h0000_0000);
    async_mode = 1'b1;
    exp_ab = ~exp_ab;
    cmd(OP_MEAS, 0, 6'h09, 1'b0);
    exp_ab = ~exp_ab;
    cmd(OP_CONF, 0, 6'h0C, 1'b1);
    chk("abort", 32'(abort_bit), 32'(exp_ab));
    chk("kind", kind_of(0), 32'h0000_000C);
    chk("run", 32'(run), 32'h0000_0000);
    cmd(OP_INIT, 1, 6'h05, 1'b0);
    ticks(1, 4);
    cmd(OP_QUERY, 1, 6'h00, 1'b1);
    chk("run", 32'(run), 32'h0000_0002);
    chk("abort", 32'(abort_bit), 32'(exp_ab));
    chk("busy", 32'(query_busy), 32'h0000_0001);
    async_mode = 1'b0;
    i_host.send(OP_IMM, arg_of(1, 6'h00), 1'b0);
    repeat (6) @(negedge i_clock);
    chk("run", 32'(run), 32'h0000_0002);
    chk("ready", 32'(rx_ready), 32'h0000_0000);
    query_done = 1'b1;
    @(negedge i_clock);
    query_done = 1'b0;
    wait_idle;
    chk("run", 32'(run), 32'h0000_0000);
    chk("abort", 32'(abort_bit), 32'(exp_ab));
    chk("busy", 32'(query_busy), 32'h0000_0000);
    ticks(1, 2);
    chk("count", count_of(1), 32'h0000_0004);
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clock);
    i_rst_n = 1'b1;
    exp_ab = ABORT_BIT_RST;
    chk("ready", 32'(rx_ready), 32'h0000_0001);
    chk("abort", 32'(abort_bit), 32'(exp_ab));
    chk("run", 32'(run), 32'h0000_0000);
    give_verdict;
  end
endmodule
